// file: rtl/mabce_consts.svh
// constants for the add and bit-clear execution slice
`ifndef MABCE_CONSTS_SVH
`define MABCE_CONSTS_SVH

// register byte offsets on the control bus
`define MABCE_OFF_INSTR 8'h00
`define MABCE_OFF_STATUS 8'h04
`define MABCE_OFF_ACC 8'h08
`define MABCE_OFF_PEEK_ADDR 8'h0c
`define MABCE_OFF_PEEK_DATA 8'h10

// instruction word layout: op[19:16] page[15] dest[14] addr[13:8] lit[7:0]
`define MABCE_INSTR_W 20
`define MABCE_OP_W 4
`define MABCE_RADDR_W 6
`define MABCE_MEM_AW 7

// status register bit positions
`define MABCE_ST_Z 0
`define MABCE_ST_DC 1
`define MABCE_ST_C 2
`define MABCE_ST_TO 3
`define MABCE_ST_PD 4
`define MABCE_ST_BUSY 5

// page mapping inside the register memory
`define MABCE_RPAGE_LAST 7'h3f
`define MABCE_SPAGE_BASE 7'h40
`define MABCE_MEM_DEPTH 80

// reset values
`define MABCE_RST_PD 1'b1
`define MABCE_RST_TO 1'b1
`define MABCE_RST_ACC 8'h00

// axi answers
`define MABCE_RESP_OKAY 2'h0
`define MABCE_RESP_SLVERR 2'h2

`endif

// file: rtl/mabce_pkg.sv
// types for the add and bit-clear execution slice
`include "mabce_consts.svh"

package mabce_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC
	} mabce_state_type;

	typedef enum logic [`MABCE_OP_W-1:0] {
		OP_NOP,
		OP_REG_ADD_WITH_CARRY,
		OP_REG_ADD,
		OP_IMM_ADD_WITH_CARRY,
		OP_IMM_ADD,
		OP_REG_AND,
		OP_BIT_CLEAR_INSTR,
		OP_SLEEP,
		OP_WATCHDOG_KICK_INSTR
	} mabce_op_type;

	typedef struct packed {
		logic [`MABCE_OP_W-1:0] op;
		logic page;
		logic dest;
		logic [`MABCE_RADDR_W-1:0] addr;
		logic [7:0] lit;
	} mabce_instr_type;

	typedef struct packed {
		mabce_state_type st;
		mabce_instr_type ins;
		logic [7:0] acc;
		logic z;
		logic dc;
		logic c;
		logic pd;
		logic to;
		logic sleep_stb;
		logic kick_stb;
		logic [`MABCE_MEM_AW-1:0] peek_addr;
		logic [7:0] peek_data;
		logic peek_vld;
		logic aw_held;
		logic w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} mabce_regs_type;

endpackage

// file: rtl/mabce_regfile.sv
// register page memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none

module mabce_regfile #(
	parameter int DEPTH = 80,
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] mem_q [DEPTH];

	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		// read before write: a same-cycle write shows one cycle later
		if (!nrst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem_q[raddr_i];
		end
	end

endmodule // mabce_regfile

`default_nettype wire

// file: rtl/mabce_exec.sv
// add, and, bit-clear execution slice with axi4-lite control port
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mabce_consts.svh"

// Function
// - power-down flag is 1 after reset and a watchdog kick, 0 after sleep.
// - time-out flag is 1 after reset, a watchdog kick or a sleep.
// - time-out flag goes to zero when the watchdog counter times out.
// - main page register operand reaches 64 locations 0x00 to 0x3f.
// - secondary page register operand is 4 bits wide, 16 locations.
// - destination 0 writes the working register, 1 the addressed one.
// - register add with carry sums acc, operand, carry; 1 cycle, Z DC C. Here it takes two cycles, ST_FETCH then ST_EXEC.
// - register add sums acc and operand, no carry in; 1 cycle, Z DC C. Here it takes two cycles, ST_FETCH then ST_EXEC.
// - immediate add with carry: literal, acc and carry into acc, Z DC C.
// - immediate add: literal and acc, no carry, into acc, Z DC C.
// - register and writes the chosen destination, changing only Z.
// - bit clear zeroes the one bit (0 to 7) picked by lit in the addressed register, flags kept.
// - carry is one exactly when an addition carries out of bit seven.
module mabce_exec
	import mabce_pkg::*;
#(
	parameter int MEM_DEPTH = `MABCE_MEM_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic watchdog_timeout_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [7:0] working_register_o,
	output logic zero_flag_o,
	output logic half_carry_flag_o,
	output logic carry_flag_o,
	output logic power_down_flag_o,
	output logic time_out_flag_o,
	output logic sleep_strobe_o,
	output logic watchdog_kick_instr_o
);

	localparam mabce_regs_type RESET_VAL = '{
		st: ST_IDLE,
		ins: '0,
		acc: `MABCE_RST_ACC,
		pd: `MABCE_RST_PD,
		to: `MABCE_RST_TO,
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		default: '0
	};

	mabce_regs_type s_q;
	mabce_regs_type s_d;
	logic mem_we;
	logic [`MABCE_MEM_AW-1:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [`MABCE_MEM_AW-1:0] mem_raddr;
	logic [7:0] mem_rd;
	logic [`MABCE_MEM_AW-1:0] oper_addr;
	logic [7:0] opnd_b;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] half5;
	logic [7:0] and8;
	logic [7:0] clr8;
	logic needs_read;
	mabce_instr_type new_ins;
	default clocking cb_chk @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	mabce_regfile #(
		.DEPTH(MEM_DEPTH),
		.AW(`MABCE_MEM_AW),
		.DW(8)
	) u_regfile (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rd)
	);

	// main page sits at 0x00..0x3f, secondary page right above it
	always_comb begin
		if (s_q.ins.page) begin
			oper_addr = `MABCE_SPAGE_BASE + {3'h0, s_q.ins.addr[3:0]};
		end else begin
			oper_addr = {1'b0, s_q.ins.addr};
		end
	end

	always_comb begin
		new_ins = mabce_instr_type'(s_q.wdata[`MABCE_INSTR_W-1:0]);
		unique case (new_ins.op)
			OP_REG_ADD_WITH_CARRY, OP_REG_ADD, OP_REG_AND,
			OP_BIT_CLEAR_INSTR: needs_read = 1'b1;
			default: needs_read = 1'b0;
		endcase
	end

	// shared adder; immediate forms take the literal instead of memory
	always_comb begin
		unique case (s_q.ins.op)
			OP_IMM_ADD_WITH_CARRY, OP_IMM_ADD: opnd_b = s_q.ins.lit;
			default: opnd_b = mem_rd;
		endcase
		cin = (s_q.ins.op == OP_REG_ADD_WITH_CARRY ||
			s_q.ins.op == OP_IMM_ADD_WITH_CARRY) ? s_q.c : 1'b0;
		sum9 = {1'b0, s_q.acc} + {1'b0, opnd_b} + {8'h00, cin};
		half5 = {1'b0, s_q.acc[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
		and8 = s_q.acc & opnd_b;
		clr8 = mem_rd & ~(8'h01 << s_q.ins.lit[2:0]);
	end

	always_comb begin
		s_d = s_q;
		s_d.sleep_stb = 1'b0;
		s_d.kick_stb = 1'b0;
		mem_we = 1'b0;
		mem_waddr = oper_addr;
		mem_wdata = sum9[7:0];
		mem_raddr = (s_q.st == ST_FETCH) ? oper_addr : s_q.peek_addr;
		// the read port serves the peek window except while fetching
		s_d.peek_vld = (s_q.st != ST_FETCH);
		if (s_q.peek_vld) begin
			s_d.peek_data = mem_rd;
		end
		if (watchdog_timeout_i) begin
			s_d.to = 1'b0;
		end

		unique case (s_q.st)
			ST_IDLE: begin
			end
			ST_FETCH: s_d.st = ST_EXEC;
			ST_EXEC: begin
				s_d.st = ST_IDLE;
				unique case (s_q.ins.op)
					OP_REG_ADD_WITH_CARRY, OP_REG_ADD: begin
						s_d.c = sum9[8];
						s_d.dc = half5[4];
						s_d.z = (sum9[7:0] == 8'h00);
						if (s_q.ins.dest) begin
							mem_we = 1'b1;
						end else begin
							s_d.acc = sum9[7:0];
						end
					end
					OP_IMM_ADD_WITH_CARRY, OP_IMM_ADD: begin
						s_d.c = sum9[8];
						s_d.dc = half5[4];
						s_d.z = (sum9[7:0] == 8'h00);
						s_d.acc = sum9[7:0];
					end
					OP_REG_AND: begin
						s_d.z = (and8 == 8'h00);
						mem_wdata = and8;
						if (s_q.ins.dest) begin
							mem_we = 1'b1;
						end else begin
							s_d.acc = and8;
						end
					end
					OP_BIT_CLEAR_INSTR: begin
						mem_we = 1'b1;
						mem_wdata = clr8;
					end
					OP_SLEEP: begin
						// instruction outranks a timeout in the same cycle
						s_d.pd = 1'b0;
						s_d.to = 1'b1;
						s_d.sleep_stb = 1'b1;
					end
					OP_WATCHDOG_KICK_INSTR: begin
						s_d.pd = 1'b1;
						s_d.to = 1'b1;
						s_d.kick_stb = 1'b1;
					end
					default: begin
					end
				endcase
			end
			default: s_d.st = ST_IDLE;
		endcase

		// write channel: address and data land in either order
		if (s_axi_awvalid_i && s_q.awready) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_q.wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata_i;
			s_d.wstrb = s_axi_wstrb_i;
		end
		// writes wait for an idle core so acc and instr never race
		if (s_q.aw_held && s_q.w_held && !s_q.bvalid &&
			s_q.st == ST_IDLE) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = `MABCE_RESP_OKAY;
			unique case (s_q.awaddr)
				`MABCE_OFF_INSTR: begin
					if (|s_q.wstrb) begin
						s_d.ins = new_ins;
						s_d.st = needs_read ? ST_FETCH : ST_EXEC;
					end
				end
				`MABCE_OFF_ACC: begin
					if (s_q.wstrb[0]) begin
						s_d.acc = s_q.wdata[7:0];
					end
				end
				`MABCE_OFF_PEEK_ADDR: begin
					if (s_q.wstrb[0]) begin
						s_d.peek_addr = s_q.wdata[`MABCE_MEM_AW-1:0];
					end
				end
				`MABCE_OFF_STATUS, `MABCE_OFF_PEEK_DATA: begin
				end
				default: s_d.bresp = `MABCE_RESP_SLVERR;
			endcase
		end
		if (s_q.bvalid && s_axi_bready_i) begin
			s_d.bvalid = 1'b0;
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
		end
		s_d.awready = !s_d.aw_held;
		s_d.wready = !s_d.w_held;

		// read channel: answer one cycle after the address is taken
		if (s_axi_arvalid_i && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = `MABCE_RESP_OKAY;
			s_d.rdata = '0;
			unique case (s_axi_araddr_i)
				`MABCE_OFF_INSTR: s_d.rdata[`MABCE_INSTR_W-1:0] = s_q.ins;
				`MABCE_OFF_STATUS: begin
					s_d.rdata[`MABCE_ST_Z] = s_q.z;
					s_d.rdata[`MABCE_ST_DC] = s_q.dc;
					s_d.rdata[`MABCE_ST_C] = s_q.c;
					s_d.rdata[`MABCE_ST_TO] = s_q.to;
					s_d.rdata[`MABCE_ST_PD] = s_q.pd;
					s_d.rdata[`MABCE_ST_BUSY] = (s_q.st != ST_IDLE);
				end
				`MABCE_OFF_ACC: s_d.rdata[7:0] = s_q.acc;
				`MABCE_OFF_PEEK_ADDR:
					s_d.rdata[`MABCE_MEM_AW-1:0] = s_q.peek_addr;
				`MABCE_OFF_PEEK_DATA: s_d.rdata[7:0] = s_q.peek_data;
				default: s_d.rresp = `MABCE_RESP_SLVERR;
			endcase
		end
		if (s_q.rvalid && s_axi_rready_i) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			s_q <= RESET_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready_o = s_q.awready;
	assign s_axi_wready_o = s_q.wready;
	assign s_axi_bvalid_o = s_q.bvalid;
	assign s_axi_bresp_o = s_q.bresp;
	assign s_axi_arready_o = s_q.arready;
	assign s_axi_rvalid_o = s_q.rvalid;
	assign s_axi_rresp_o = s_q.rresp;
	assign s_axi_rdata_o = s_q.rdata;
	assign working_register_o = s_q.acc;
	assign zero_flag_o = s_q.z;
	assign half_carry_flag_o = s_q.dc;
	assign carry_flag_o = s_q.c;
	assign power_down_flag_o = s_q.pd;
	assign time_out_flag_o = s_q.to;
	assign sleep_strobe_o = s_q.sleep_stb;
	assign watchdog_kick_instr_o = s_q.kick_stb;

	a_sleep_flags: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_SLEEP) |=>
		(!power_down_flag_o && time_out_flag_o && sleep_strobe_o))
		else $error("sleep did not clear pd and set to");
	a_kick_flags: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_WATCHDOG_KICK_INSTR) |=>
		(power_down_flag_o && time_out_flag_o))
		else $error("watchdog kick did not set pd and to");
	a_timeout_clear: assert property (
		(watchdog_timeout_i && !(s_q.st == ST_EXEC &&
		(s_q.ins.op == OP_SLEEP || s_q.ins.op == OP_WATCHDOG_KICK_INSTR)))
		|=> !time_out_flag_o)
		else $error("timeout did not clear time-out flag");
	a_rpage_addr: assert property (
		(s_q.st == ST_FETCH && !s_q.ins.page) |->
		(mem_raddr <= `MABCE_RPAGE_LAST && mem_raddr[5:0] == s_q.ins.addr))
		else $error("main page operand address wrong");
	a_spage_addr: assert property (
		(s_q.st == ST_FETCH && s_q.ins.page) |->
		(mem_raddr[6:4] == 3'h4 && mem_raddr[3:0] == s_q.ins.addr[3:0]))
		else $error("secondary page operand address wrong");
	a_dest_select: assert property (
		(s_q.st == ST_EXEC && (s_q.ins.op == OP_REG_ADD ||
		s_q.ins.op == OP_REG_AND || s_q.ins.op == OP_REG_ADD_WITH_CARRY))
		|-> (mem_we == s_q.ins.dest))
		else $error("destination select not honoured");
	a_reg_adc_sum: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_REG_ADD_WITH_CARRY &&
		!s_q.ins.dest) |=> ({carry_flag_o, working_register_o} ==
		{1'b0, $past(s_q.acc)} + {1'b0, $past(mem_rd)} +
		{8'h00, $past(carry_flag_o)}))
		else $error("register add with carry wrong");
	a_reg_add_sum: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_REG_ADD && !s_q.ins.dest) |=>
		({carry_flag_o, working_register_o} ==
		{1'b0, $past(s_q.acc)} + {1'b0, $past(mem_rd)}))
		else $error("register add wrong");
	a_imm_adc_sum: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_IMM_ADD_WITH_CARRY) |=>
		({carry_flag_o, working_register_o} ==
		{1'b0, $past(s_q.acc)} + {1'b0, $past(s_q.ins.lit)} +
		{8'h00, $past(carry_flag_o)}))
		else $error("immediate add with carry wrong");
	a_imm_add_flags: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_IMM_ADD) |=>
		(working_register_o == $past(s_q.acc) + $past(s_q.ins.lit) &&
		zero_flag_o == (working_register_o == 8'h00)))
		else $error("immediate add wrong");
	a_and_flags: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_REG_AND) |=>
		($stable(carry_flag_o) && $stable(half_carry_flag_o) &&
		zero_flag_o == (($past(s_q.acc) & $past(mem_rd)) == 8'h00)))
		else $error("register and touched carry flags");
	a_bit_clear: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_BIT_CLEAR_INSTR) |->
		(mem_we && mem_wdata[s_q.ins.lit[2:0]] == 1'b0 &&
		(mem_wdata | (8'h01 << s_q.ins.lit[2:0])) ==
		(mem_rd | (8'h01 << s_q.ins.lit[2:0]))) ##1
		($stable(zero_flag_o) && $stable(carry_flag_o) &&
		$stable(half_carry_flag_o)))
		else $error("bit clear wrong or flags changed");
	a_half_carry: assert property (
		(s_q.st == ST_EXEC && s_q.ins.op == OP_REG_ADD) |=>
		(half_carry_flag_o == ((({1'b0, $past(s_q.acc[3:0])} +
		{1'b0, $past(mem_rd[3:0])}) >> 4) == 5'h01)))
		else $error("half carry wrong");

endmodule // mabce_exec

`default_nettype wire

// file: test/mcu_add_and_bitclear_exec_tb.sv
// self-checking bench for the add and bit-clear execution slice
`timescale 1ns/1ps
`default_nettype none
`include "mabce_consts.svh"

module mcu_add_and_bitclear_exec_tb
	import mabce_pkg::*;
;
	logic sys_clk, nrst, wd, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, acc;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic zf, dcf, cf, pdf, tof, slp, kick;
	logic [1:0] bresp, rresp, r;
	logic [7:0] e;
	int failures, comparisons, nslp, nkick, n0, k0;

	mabce_exec dut (.sys_clk_i(sys_clk), .nrst_i(nrst),
		.watchdog_timeout_i(wd), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.working_register_o(acc), .zero_flag_o(zf),
		.half_carry_flag_o(dcf), .carry_flag_o(cf),
		.power_down_flag_o(pdf), .time_out_flag_o(tof),
		.sleep_strobe_o(slp), .watchdog_kick_instr_o(kick));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// strobes are one cycle wide, so count them rather than poll
	always @(posedge sys_clk) begin
		if (slp === 1'b1) nslp++;
		if (kick === 1'b1) nkick++;
	end

	task automatic test_done();
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] resp);
		bit ga, gw, done;
		int n;
		ga = 0;
		gw = 0;
		done = 0;
		resp = 2'h3;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100 && !done; n++) begin
			@(posedge sys_clk);
			if (!ga && awready) begin
				ga = 1;
				awvalid <= 1'b0;
			end
			if (!gw && wready) begin
				gw = 1;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				done = 1;
			end
		end
		if (!done) failures++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		bit done;
		int n;
		done = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100 && !done; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				resp = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
		if (!done) failures++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] resp;
		axw(a, v, resp);
		chk("bresp", `MABCE_RESP_OKAY, resp);
	endtask

	function automatic logic [31:0] ins(input mabce_op_type op,
		input logic pg, input logic dst, input logic [5:0] a,
		input logic [7:0] l);
		return {12'h000, op, pg, dst, a, l};
	endfunction

	// results of register forms land three edges after the write
	task automatic run(input logic [31:0] i);
		wr(`MABCE_OFF_INSTR, i);
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic flags(input logic z, input logic h, input logic c);
		chk("zero", z, zf);
		chk("half carry", h, dcf);
		chk("carry", c, cf);
	endtask

	task automatic peek(input logic [6:0] idx, input logic [7:0] exp);
		logic [31:0] v;
		logic [1:0] resp;
		wr(`MABCE_OFF_PEEK_ADDR, {25'h0, idx});
		repeat (3) @(posedge sys_clk);
		rd(`MABCE_OFF_PEEK_DATA, v, resp);
		chk("peek", exp, v[7:0]);
	endtask

	// memory is not reset: and with zero first to get a defined byte
	task automatic set_reg(input logic pg, input logic [5:0] a,
		input logic [7:0] v);
		wr(`MABCE_OFF_ACC, 32'h0);
		run(ins(OP_REG_AND, pg, 1'b1, a, 8'h00));
		wr(`MABCE_OFF_ACC, {24'h0, v});
		run(ins(OP_REG_ADD, pg, 1'b1, a, 8'h00));
	endtask

	task automatic set_carry();
		wr(`MABCE_OFF_ACC, 32'hff);
		run(ins(OP_IMM_ADD, 1'b0, 1'b0, 6'h00, 8'h01));
		flags(1'b1, 1'b1, 1'b1);
	endtask

	task automatic wd_pulse();
		@(posedge sys_clk);
		wd <= 1'b1;
		@(posedge sys_clk);
		wd <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic power(input mabce_op_type op, input logic pd,
		input logic to);
		n0 = nslp;
		k0 = nkick;
		run(ins(op, 1'b0, 1'b0, 6'h00, 8'h00));
		chk("pd", pd, pdf);
		chk("to", to, tof);
		chk("sleep strobes", n0 + (op == OP_SLEEP), nslp);
		chk("kick strobes", k0 + (op == OP_WATCHDOG_KICK_INSTR), nkick);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		test_done();
	end

	initial begin
		{nrst, wd, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		chk("pd", 1'b1, pdf);
		chk("to", 1'b1, tof);
		flags(1'b0, 1'b0, 1'b0);
		chk("acc", 8'h00, acc);
		axw(8'h14, 32'h1, r);
		chk("unmapped bresp", `MABCE_RESP_SLVERR, r);
		rd(8'h14, d, r);
		chk("unmapped rresp", `MABCE_RESP_SLVERR, r);
		chk("unmapped rdata", 32'h0, d);
		wr(`MABCE_OFF_STATUS, 32'h0);
		rd(`MABCE_OFF_STATUS, d, r);
		chk("status", 32'h18, d);
		set_reg(1'b0, 6'h06, 8'haf);
		set_carry();
		wr(`MABCE_OFF_ACC, 32'h5a);
		run(ins(OP_REG_AND, 1'b0, 1'b1, 6'h06, 8'h00));
		chk("acc", 8'h5a, acc);
		flags(1'b0, 1'b1, 1'b1);
		peek(7'd6, 8'h0a);
		wr(`MABCE_OFF_ACC, 32'h50);
		run(ins(OP_REG_AND, 1'b0, 1'b0, 6'h06, 8'h00));
		chk("acc", 8'h00, acc);
		flags(1'b1, 1'b1, 1'b1);
		set_reg(1'b0, 6'h05, 8'h34);
		set_carry();
		wr(`MABCE_OFF_ACC, 32'h12);
		run(ins(OP_REG_ADD_WITH_CARRY, 1'b0, 1'b1, 6'h05, 8'h00));
		peek(7'd5, 8'h47);
		chk("acc", 8'h12, acc);
		flags(1'b0, 1'b0, 1'b0);
		set_carry();
		wr(`MABCE_OFF_ACC, 32'h12);
		run(ins(OP_REG_ADD, 1'b0, 1'b0, 6'h05, 8'h00));
		chk("acc", 8'h59, acc);
		flags(1'b0, 1'b0, 1'b0);
		wr(`MABCE_OFF_ACC, 32'hb9);
		run(ins(OP_REG_ADD, 1'b0, 1'b0, 6'h05, 8'h00));
		chk("acc", 8'h00, acc);
		flags(1'b1, 1'b1, 1'b1);
		peek(7'd5, 8'h47);
		set_carry();
		wr(`MABCE_OFF_ACC, 32'h12);
		run(ins(OP_IMM_ADD_WITH_CARRY, 1'b0, 1'b0, 6'h00, 8'h34));
		chk("acc", 8'h47, acc);
		flags(1'b0, 1'b0, 1'b0);
		set_carry();
		wr(`MABCE_OFF_ACC, 32'h0f);
		run(ins(OP_IMM_ADD_WITH_CARRY, 1'b0, 1'b0, 6'h00, 8'h00));
		chk("acc", 8'h10, acc);
		flags(1'b0, 1'b1, 1'b0);
		set_carry();
		wr(`MABCE_OFF_ACC, 32'h12);
		run(ins(OP_IMM_ADD, 1'b0, 1'b0, 6'h00, 8'h34));
		chk("acc", 8'h46, acc);
		flags(1'b0, 1'b0, 1'b0);
		wr(`MABCE_OFF_ACC, 32'h80);
		run(ins(OP_IMM_ADD, 1'b0, 1'b0, 6'h00, 8'h80));
		flags(1'b1, 1'b0, 1'b1);
		// a no-op must leave acc and the Z, DC and C flags alone
		run(ins(OP_NOP, 1'b0, 1'b0, 6'h00, 8'hff));
		chk("acc", 8'h00, acc);
		flags(1'b1, 1'b0, 1'b1);
		set_reg(1'b0, 6'h0f, 8'h11);
		set_reg(1'b0, 6'h3f, 8'hff);
		set_carry();
		e = 8'hff;
		for (int b = 0; b < 8; b++) begin
			run(ins(OP_BIT_CLEAR_INSTR, 1'b0, 1'b0, 6'h3f, 8'(b)));
			e[b] = 1'b0;
			peek(7'd63, e);
			flags(1'b1, 1'b1, 1'b1);
		end
		set_reg(1'b1, 6'h0f, 8'h5a);
		run(ins(OP_BIT_CLEAR_INSTR, 1'b1, 1'b0, 6'h0f, 8'h03));
		peek(7'd79, 8'h52);
		peek(7'd15, 8'h11);
		power(OP_SLEEP, 1'b0, 1'b1);
		wd_pulse();
		chk("to", 1'b0, tof);
		chk("pd", 1'b0, pdf);
		// second reset with both flags low: power-up must raise them
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		chk("pd", 1'b1, pdf);
		chk("to", 1'b1, tof);
		chk("acc", 8'h00, acc);
		power(OP_SLEEP, 1'b0, 1'b1);
		wd_pulse();
		chk("to", 1'b0, tof);
		power(OP_WATCHDOG_KICK_INSTR, 1'b1, 1'b1);
		test_done();
	end
endmodule // mcu_add_and_bitclear_exec_tb

`default_nettype wire
